// >>> pkg/pbsp_map.vh
// Purpose: shared constants of the pipelined burst sram port
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef PBSP_MAP_VH
`define PBSP_MAP_VH

// default geometry
`define PBSP_ADDR_W        6
`define PBSP_LANES         2
`define PBSP_LANE_W        8

// burst counter acts on the two low address bits
`define PBSP_CNT_W         2

// burst-order strap levels
`define PBSP_ORDER_LINEAR  1'b0
`define PBSP_ORDER_INTLV   1'b1

// write buffer depth in words
`define PBSP_FIFO_DEPTH    32

// access states
`define PBSP_ST_DESEL      2'h0
`define PBSP_ST_READ       2'h1
`define PBSP_ST_WRITE      2'h2

`endif

// >>> logic/pbsp_top.v
// Purpose: pipelined burst sram port, device side, with flop storage
// Assumes: controller runs on clk; output_en_n and the strap are pins
// Notes:   writes reach the array through a 32-word buffer
`timescale 1ns/1ps
`include "pbsp_map.vh"

module pbsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `PBSP_FIFO_DEPTH
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // step with wrap, so a depth that is not a power of two still works
  function [PW-1:0] ptr_step;
    input [PW-1:0] ptr;
    begin
      if (ptr == DEPTH[PW-1:0] - 1'b1) begin
        ptr_step = {PW{1'b0}};
      end else begin
        ptr_step = ptr + 1'b1;
      end
    end
  endfunction

  reg  [WIDTH-1:0] store [0:DEPTH-1];
  reg  [PW-1:0]    wr_ptr;
  reg  [PW-1:0]    rd_ptr;
  reg  [PW:0]      fill;
  wire             push;
  wire             pop;

  // fill is one bit wider than the pointers so full and empty differ
  assign in_ready  = (fill != DEPTH[PW:0]);
  assign out_valid = (fill != {(PW+1){1'b0}});
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= {PW{1'b0}};
      rd_ptr <= {PW{1'b0}};
      fill   <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= ptr_step(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_step(rd_ptr);
      end
      if (push & ~pop) begin
        fill <= fill + 1'b1;
      end else if (pop & ~push) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule // pbsp_fifo

// How it works
// - advance high on a taken edge steps the burst counter of a read or write, address ignored.
// - advance low on a taken edge loads the pin address as new access.
// - inputs other than output enable and strap are taken on rising clk, only when clock qualify is low.
// - clock qualify high freezes the access state and read data and stretches the cycle.
// - selected only when first and third selects low, second high.
// - pins drive only while output enable is low, else act as inputs.
// - outputs stay off in write data cycle, deselect and after deselect.
// - read data appears one cycle after its address was taken.
// - input data pins are registered on the rising edge.
// - parity lines act like data, written under their own lane select.
// - strap high gives interleaved burst order, low gives linear order.
// - an unconnected strap reads as high, so interleaved order.
// - active low lane selects, sampled on edge, gate each lane's write.
// - burst counter touches only the two low address bits and wraps.
module pbsp_top #(
  parameter ADDR_W  = `PBSP_ADDR_W,
  parameter LANES   = `PBSP_LANES,
  parameter BUF_DEP = `PBSP_FIFO_DEPTH
) (
  input  wire                          clk,
  input  wire                          sys_rst,
  input  wire [ADDR_W-1:0]             addr_in,
  input  wire                          advance_or_load,
  input  wire                          clock_qualify_n,
  input  wire                          chip_sel_first_n,
  input  wire                          chip_sel_second,
  input  wire                          chip_sel_third_n,
  input  wire                          write_en_n,
  input  wire [LANES-1:0]              byte_write_sel_n,
  input  wire                          output_en_n,
  input  wire                          burst_order_strap,
  input  wire [LANES*`PBSP_LANE_W-1:0] data_in,
  output reg  [LANES*`PBSP_LANE_W-1:0] data_out,
  output reg                           data_oe_n,
  input  wire [LANES-1:0]              parity_in,
  output reg  [LANES-1:0]              parity_out,
  output reg                           parity_oe_n,
  output reg                           write_buffer_ready
);
  localparam DW     = LANES * `PBSP_LANE_W;
  localparam LW     = `PBSP_LANE_W;
  localparam CW     = `PBSP_CNT_W;
  localparam WORDS  = 1 << ADDR_W;
  localparam FW     = ADDR_W + LANES + DW + LANES;
  localparam ST_DESEL = `PBSP_ST_DESEL;
  localparam ST_READ  = `PBSP_ST_READ;
  localparam ST_WRITE = `PBSP_ST_WRITE;

  // low address bits of a burst beat
  function [CW-1:0] burst_low;
    input [CW-1:0] start;
    input [CW-1:0] count;
    input          order;
    begin
      if (order == `PBSP_ORDER_INTLV) begin
        burst_low = start ^ count;
      end else begin
        burst_low = start + count;
      end
    end
  endfunction

  // full address of a burst beat; upper bits never move in a burst
  function [ADDR_W-1:0] beat_addr;
    input [ADDR_W-1:0] base;
    input [CW-1:0]     count;
    input              order;
    begin
      beat_addr = {base[ADDR_W-1:CW],
                   burst_low(base[CW-1:0], count, order)};
    end
  endfunction

  // one decode for data and parity so the two enables never split
  function pins_off;
    input want_drive;
    input oe_pin_n;
    begin
      pins_off = ~(want_drive & ~oe_pin_n);
    end
  endfunction

  // pin synchronisers; the first stage feeds only the second
  reg              oe_meta;
  reg              oe_sync;
  reg              order_meta;
  reg              order_sync;

  // access state, held while clock qualify is high
  reg  [1:0]       st;
  reg  [ADDR_W-1:0] base_addr;
  reg  [ADDR_W-1:0] cur_addr;
  reg  [CW-1:0]    burst_cnt;
  reg  [LANES-1:0] lane_n;
  reg              drive;

  // write data cycle registers
  reg  [DW-1:0]    in_data;
  reg  [LANES-1:0] in_par;
  reg  [ADDR_W-1:0] wr_addr;
  reg  [LANES-1:0] wr_lane_n;
  reg              wr_pend;

  // storage
  reg  [DW-1:0]    mem_data [0:WORDS-1];
  reg  [LANES-1:0] mem_par  [0:WORDS-1];

  wire             taken;
  wire             sel_now;
  wire             rd_cycle;
  wire [CW-1:0]    next_cnt;
  wire             next_drive;
  wire             buf_in_ready;
  wire             buf_out_valid;
  wire             buf_out_ready;
  wire [FW-1:0]    buf_out_data;
  wire [ADDR_W-1:0] dr_addr;
  wire [LANES-1:0] dr_lane_n;
  wire [DW-1:0]    dr_data;
  wire [LANES-1:0] dr_par;
  wire [DW-1:0]    merged_data;
  wire [LANES-1:0] merged_par;

  assign taken   = ~clock_qualify_n;
  assign sel_now = ~chip_sel_first_n & chip_sel_second
                   & ~chip_sel_third_n;
  // the array is single ported: a read data cycle blocks the drain
  assign rd_cycle      = taken & (st == ST_READ);
  assign buf_out_ready = ~rd_cycle;
  assign next_cnt      = burst_cnt + 1'b1;
  assign next_drive    = taken ? (st == ST_READ) : drive;

  assign dr_addr   = buf_out_data[FW-1 -: ADDR_W];
  assign dr_lane_n = buf_out_data[DW+LANES +: LANES];
  assign dr_data   = buf_out_data[LANES +: DW];
  assign dr_par    = buf_out_data[LANES-1:0];

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      assign merged_data[g*LW +: LW] = dr_lane_n[g]
        ? mem_data[dr_addr][g*LW +: LW] : dr_data[g*LW +: LW];
      assign merged_par[g] = dr_lane_n[g]
        ? mem_par[dr_addr][g] : dr_par[g];
    end
  endgenerate

  always @(posedge clk) begin
    if (sys_rst) begin
      oe_meta    <= 1'b1;
      oe_sync    <= 1'b1;
      // strap reads high until sampled: an open pad has a pull-up
      order_meta <= `PBSP_ORDER_INTLV;
      order_sync <= `PBSP_ORDER_INTLV;
    end else begin
      oe_meta    <= output_en_n;
      oe_sync    <= oe_meta;
      order_meta <= burst_order_strap;
      order_sync <= order_meta;
    end
  end

  // address cycle and access state
  always @(posedge clk) begin
    if (sys_rst) begin
      st        <= ST_DESEL;
      base_addr <= {ADDR_W{1'b0}};
      cur_addr  <= {ADDR_W{1'b0}};
      burst_cnt <= {CW{1'b0}};
      lane_n    <= {LANES{1'b1}};
      drive     <= 1'b0;
    end else if (taken) begin
      drive  <= next_drive;
      lane_n <= byte_write_sel_n;
      if (!advance_or_load) begin
        base_addr <= addr_in;
        cur_addr  <= addr_in;
        burst_cnt <= {CW{1'b0}};
        if (sel_now) begin
          st <= write_en_n ? ST_READ : ST_WRITE;
        end else begin
          st <= ST_DESEL;
        end
      end else begin
        case (st)
          // advance while deselected stays idle; a load must follow
          ST_DESEL: begin
            st <= ST_DESEL;
          end
          ST_READ, ST_WRITE: begin
            burst_cnt <= next_cnt;
            cur_addr  <= beat_addr(base_addr, next_cnt, order_sync);
          end
          default: begin
            st <= ST_DESEL;
          end
        endcase
      end
    end
  end

  // data cycle: read out or capture write data
  // the pins are sampled on every taken edge; only a write data
  // cycle turns the sample into a buffer push
  always @(posedge clk) begin
    if (sys_rst) begin
      data_out   <= {DW{1'b0}};
      parity_out <= {LANES{1'b0}};
      in_data    <= {DW{1'b0}};
      in_par     <= {LANES{1'b0}};
      wr_addr    <= {ADDR_W{1'b0}};
      wr_lane_n  <= {LANES{1'b1}};
      wr_pend    <= 1'b0;
    end else begin
      wr_pend <= taken & (st == ST_WRITE);
      if (taken) begin
        in_data   <= data_in;
        in_par    <= parity_in;
        wr_addr   <= cur_addr;
        wr_lane_n <= lane_n;
        if (st == ST_READ) begin
          data_out   <= mem_data[cur_addr];
          parity_out <= mem_par[cur_addr];
        end
      end
    end
  end

  // pins drive only in a read data cycle with output enable low
  always @(posedge clk) begin
    if (sys_rst) begin
      data_oe_n          <= 1'b1;
      parity_oe_n        <= 1'b1;
      write_buffer_ready <= 1'b0;
    end else begin
      data_oe_n          <= pins_off(next_drive, oe_sync);
      parity_oe_n        <= pins_off(next_drive, oe_sync);
      write_buffer_ready <= buf_in_ready;
    end
  end

  // a write beat taken while the buffer is full is lost
  pbsp_fifo #(
    .WIDTH (FW),
    .DEPTH (BUF_DEP)
  ) u_wbuf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (wr_pend),
    .in_ready  (buf_in_ready),
    .in_data   ({wr_addr, wr_lane_n, in_data, in_par}),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // drain merges only the enabled lanes into the stored word
  // limitation: a read of a word still in the buffer sees the old
  // contents; leave a few cycles between a write and its read back
  always @(posedge clk) begin
    if (buf_out_valid & buf_out_ready) begin
      mem_data[dr_addr] <= merged_data;
      mem_par[dr_addr]  <= merged_par;
    end
  end
endmodule // pbsp_top

// >>> sim/pbsp_asserts.sv
// Purpose: pin checks of the burst sram port
// Assumes: one clock, sync reset high
// Notes:   windows allow for the enable sync lag
`timescale 1ns/1ps
module pbsp_asserts #(parameter LANES = 2) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               advance_or_load,
  input wire logic               clock_qualify_n,
  input wire logic               chip_sel_first_n,
  input wire logic               chip_sel_second,
  input wire logic               chip_sel_third_n,
  input wire logic               write_en_n,
  input wire logic               output_en_n,
  input wire logic [LANES*8-1:0] data_out,
  input wire logic               data_oe_n,
  input wire logic               parity_oe_n
);
  wire tk = !clock_qualify_n;
  wire ld = tk && !advance_or_load;
  wire sl = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_OE_PAIR: assert property (parity_oe_n == data_oe_n)
    else $error("oe pair");
  AST_FREEZE: assert property (!tk |=> $stable(data_out) && $stable(data_oe_n))
    else $error("moved while held");
  AST_TAKEN: assert property (!$stable(data_out) |-> $past(tk) || $past(sys_rst))
    else $error("data moved on untaken edge");
  AST_OE_OFF: assert property ((output_en_n && tk)[*4] |=> data_oe_n)
    else $error("drives with enable high");
  AST_RD_DRIVE: assert property ((!output_en_n && tk)[*3] ##1 (ld && sl && write_en_n && !output_en_n) ##1 (tk && !output_en_n) |=> !data_oe_n)
    else $error("read data not driven");
  AST_WR_MASK: assert property (ld && sl && !write_en_n ##1 tk |=> data_oe_n)
    else $error("drives in write data cycle");
  AST_DESEL: assert property (ld && !sl ##1 tk |=> data_oe_n && parity_oe_n)
    else $error("drives when deselected");
  AST_RST_OFF: assert property ($fell(sys_rst) |-> data_oe_n && data_out == '0)
    else $error("reset state wrong");
  cover property (ld && sl && write_en_n);
  cover property (ld && sl && !write_en_n ##1 tk && advance_or_load);
  cover property (!tk [*3]);
endmodule // pbsp_asserts

bind pbsp_top pbsp_asserts #(.LANES(LANES)) u_chk (
  .clk, .sys_rst, .advance_or_load, .clock_qualify_n, .chip_sel_first_n,
  .chip_sel_second, .chip_sel_third_n, .write_en_n, .output_en_n,
  .data_out, .data_oe_n, .parity_oe_n
);

// >>> sim/pbsp_ctrl_model.sv
// Purpose: bus master model on the sram pins
// Assumes: one beat per clk, tasks called by tb_top
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
module pbsp_ctrl_model (
  input  wire logic   clk,
  output logic [5:0]  addr_in,
  output logic        advance_or_load,
  output logic        clock_qualify_n,
  output logic [2:0]  sel,
  output logic        write_en_n,
  output logic [1:0]  byte_write_sel_n,
  output logic        output_en_n,
  output logic [15:0] data_in,
  output logic [1:0]  parity_in
);
  logic wr_data;
  initial begin
    {addr_in, advance_or_load, sel, write_en_n, output_en_n} = '0;
    {data_in, parity_in, wr_data} = '0;
    {clock_qualify_n, byte_write_sel_n} = '1;
  end
  task automatic beat(input logic adv, input logic [2:0] s, input logic we,
      input logic [5:0] a, input logic [1:0] bw, input logic [15:0] d,
      input logic [1:0] p);
    @(posedge clk);
    data_in <= wr_data ? d : ~data_in;
    parity_in <= wr_data ? p : ~parity_in;
    wr_data <= adv ? wr_data : (s == 3'h2 && !we);
    clock_qualify_n <= 1'h0;
    // callers load after every deselect
    {advance_or_load, sel, write_en_n, addr_in, byte_write_sel_n} <=
      {adv, s, we, a, bw};
    #1;
  endtask
  task automatic hold(input int n);
    repeat (n) begin
      @(posedge clk);
      clock_qualify_n <= 1'h1;
      addr_in <= ~addr_in;
    end
    #1;
  endtask
  task automatic set_oe(input logic v);
    @(posedge clk);
    output_en_n <= v;
    #1;
  endtask
endmodule // pbsp_ctrl_model

// >>> sim/tb_top.sv
// Purpose: self-checking bench of the burst sram port
// Assumes: default geometry, 6-bit address, two lanes
// Notes:   buffer fill is not reachable with one word drained a cycle
`timescale 1ns/1ps
module tb_top;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DES = 3'h6;
  logic clk = 0;
  logic sys_rst = 1;
  logic strap = 1; // board ties it high
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  wire [5:0]  addr_in;
  wire [2:0]  sel;
  wire [1:0]  byte_write_sel_n, parity_in, parity_out;
  wire [15:0] data_in, data_out;
  wire        advance_or_load, clock_qualify_n, write_en_n, output_en_n;
  wire        data_oe_n, parity_oe_n, write_buffer_ready;
  pbsp_ctrl_model ctrl (.clk, .addr_in, .advance_or_load, .clock_qualify_n,
    .sel, .write_en_n, .byte_write_sel_n, .output_en_n, .data_in,
    .parity_in);
  pbsp_top dut (.clk, .sys_rst, .addr_in, .advance_or_load,
    .clock_qualify_n, .chip_sel_first_n(sel[2]), .chip_sel_second(sel[1]),
    .chip_sel_third_n(sel[0]), .write_en_n, .byte_write_sel_n,
    .output_en_n, .burst_order_strap(strap), .data_in, .data_out,
    .data_oe_n, .parity_in, .parity_out, .parity_oe_n, .write_buffer_ready);
  initial forever #12.5 clk = ~clk;
  function automatic logic [15:0] pat(input logic [1:0] n);
    return {6'h2D, n, 6'h1A, n};
  endfunction
  task automatic check(input string w, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", w, e, s);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      finish_test;
    end
  end
  task automatic idle;
    ctrl.beat(0, DES, 1, 6'h00, 2'h3, 16'h0000, 2'h0);
  endtask
  task automatic rd(input logic [5:0] a);
    ctrl.beat(0, SEL, 1, a, 2'h3, 16'h0000, 2'h0);
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    sys_rst <= 1;
    strap <= s; // moved only under reset
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    repeat (3) idle;
    check("buf_ready", write_buffer_ready, 1);
  endtask
  task automatic burst_case(input logic s);
    logic [1:0] k;
    do_reset(s);
    ctrl.beat(0, SEL, 0, 6'h11, 0, 0, 0);
    for (int j = 0; j < 4; j++) // address pins ignored on advance
      ctrl.beat(j < 3, j < 3 ? SEL : DES, 0, 6'h3F, 0, pat(2'(j)), 2'(j));
    repeat (6) idle; // let the buffer drain
    for (int j = 0; j < 6; j++) begin
      if (j < 4) rd(6'h10 | 6'(j));
      else idle;
      k = 2'(j - 2);
      k = s ? k ^ 2'h1 : k - 2'h1;
      if (j > 1) begin
        check("rd_data", data_out, pat(k));
        check("rd_par", parity_out, k);
        check("rd_oe", data_oe_n, 0);
      end
    end
    rd(6'h11);
    for (int j = 0; j < 5; j++) begin
      ctrl.beat(j < 3, j < 3 ? SEL : DES, 1, 6'h00, 3, 0, 0);
      if (j > 0) check("burst", data_out, pat(2'(j - 1)));
    end
  endtask
  task automatic lanes_case;
    ctrl.beat(0, SEL, 0, 6'h20, 0, 0, 0);
    ctrl.beat(0, SEL, 0, 6'h20, 2'h1, 16'hAAAA, 2'h3);
    ctrl.beat(0, DES, 1, 0, 3, 16'h5555, 0);
    check("wr_oe", data_oe_n, 1);
    repeat (4) idle;
    rd(6'h20);
    repeat (2) idle;
    check("lane_data", data_out, 16'h55AA);
    check("lane_par", parity_out, 2'h1);
  endtask
  task automatic freeze_case;
    rd(6'h13);
    ctrl.hold(3);
    idle;
    check("held", data_out == pat(2'h2), 0);
    idle;
    check("resumed", data_out, pat(2'h2));
  endtask
  task automatic oe_case;
    logic [2:0] bad [4] = '{SEL, 3'h6, 3'h0, 3'h3};
    ctrl.set_oe(1);
    repeat (4) idle;
    foreach (bad[i]) begin
      ctrl.beat(0, bad[i], 1, 6'h20, 3, 0, 0);
      repeat (2) idle;
      check("oe_off", data_oe_n, 1);
      check("par_off", parity_oe_n, 1);
    end
    ctrl.set_oe(0);
    repeat (4) idle;
    rd(6'h20);
    repeat (2) idle;
    check("oe_on", data_oe_n, 0);
  endtask
  initial begin
    burst_case(1);
    burst_case(0);
    lanes_case;
    freeze_case;
    oe_case;
    finish_test;
  end
endmodule // tb_top
